// file: ipv_irq_vector_select.sv
// interrupt priority encoder and vector select with avalon-mm registers
// assumes timer and serial flags arrive synchronous to ref_clk and the
// core sequencer pulses vecSel in the vector cycle of a sequence
//
// What this block does
// RQ1: capture over compare over overflow, rest serial
// RQ2: serial request ORs gated rx and tx terms
// RQ3: internal request flop sets and stays set
// RQ4: internal flop cleared only by mask or reset
// RQ5: timer and serial encoder terms are combinational, never latched
// RQ6: no active source selects the serial vector
// RQ7: mask set resets both maskable flops
// RQ8: flop set still yields a maskable sequence
// RQ9: software masks before clearing an enable
// RQ10: momentary pulse sets flop, default vector used
// RQ11: reset, nmi, trap take the top pairs
// RQ12: external and strobe share one vector pair
// RQ13: timer sources take descending vector pairs
// RQ14: all serial conditions share lowest pair
// RQ15: vector fetch routed by operating mode
// RQ16: mode 0 external for two cycles after reset
// RQ17: mask bit 4 gates both maskable paths
// RQ18: encoder drives priority onto A1 through A3
// RQ19: mask bit sets at once, clears a cycle later
// RQ20: flop samples every edge, reset over set
`timescale 1ns/10ps

module ipv_irq_vector_select
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        nmiIn,
  input  wire logic        extMaskableRequest,
  input  wire logic        strobeFlag,
  input  wire logic        captureFlag,
  input  wire logic        compareFlag,
  input  wire logic        overflowFlag,
  input  wire logic        rxFullFlag,
  input  wire logic        overrunFramingFlag,
  input  wire logic        txEmptyFlag,
  input  wire logic        setMaskOp,
  input  wire logic        clearMaskOp,
  input  wire logic        vecSel,
  input  wire ipv_pkg::ipv_seq_t seqKind,
  output logic             irqPending,
  output logic             vecValid,
  output logic      [15:0] vecAddr,
  output logic      [1:0]  vecRoute
);
  import ipv_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic        maskBuffer_ff;
  logic        mask_ff;
  logic [4:0]  enable_ff;
  logic [2:0]  mode_ff;
  logic        intReq_ff;
  logic        extReq_ff;
  logic        nmi_ff;
  logic        nmiPrev_ff;
  logic [1:0]  sinceReset_ff;
  logic [2:0]  lastCode_ff;
  logic        waitReq_ff;
  logic [31:0] readData_ff;
  logic        pending_ff;
  logic        vecValid_ff;
  logic [15:0] vecAddr_ff;
  logic [1:0]  vecRoute_ff;

  logic        capTerm;
  logic        cmpTerm;
  logic        ovfTerm;
  logic        serialTerm;
  logic        intCombined;
  logic [2:0]  nxt_code;
  logic [1:0]  nxt_route;
  logic        busAccess;
  logic        maskWrite;

  assign busAccess = (avs_read | avs_write) & ~waitReq_ff;
  assign maskWrite = busAccess & avs_write & (avs_address == COND_OFS);

  // ----------------------------------------------------------------
  // source terms
  // ----------------------------------------------------------------
  // RQ5 unlatched terms
  assign capTerm    = captureFlag & enable_ff[EN_CAP_BIT];
  assign cmpTerm    = compareFlag & enable_ff[EN_CMP_BIT];
  assign ovfTerm    = overflowFlag & enable_ff[EN_OVF_BIT];
  // RQ2 serial combination
  assign serialTerm = ((rxFullFlag | overrunFramingFlag) & enable_ff[EN_RX_BIT])
                    | (txEmptyFlag & enable_ff[EN_TX_BIT]);
  assign intCombined = capTerm | cmpTerm | ovfTerm | serialTerm;

  // ----------------------------------------------------------------
  // mask bit and its buffer
  // ----------------------------------------------------------------
  // RQ19 set passes at once, clear waits one cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      maskBuffer_ff <= 1'b1;
      mask_ff       <= 1'b1;
    end else if (setMaskOp || (maskWrite && avs_writedata[MASK_BIT])) begin
      maskBuffer_ff <= 1'b1;
      mask_ff       <= 1'b1;
    end else if (clearMaskOp || maskWrite) begin
      maskBuffer_ff <= 1'b0;
      mask_ff       <= maskBuffer_ff;
    end else begin
      mask_ff <= maskBuffer_ff;
    end
  end

  // ----------------------------------------------------------------
  // request flip-flops
  // ----------------------------------------------------------------
  // RQ20 reset beats set, sampled every edge
  // RQ3 sticky set
  // RQ4 mask or reset clears
  // RQ7 set mask resets both flops
  // RQ10 a single-cycle term still sets the flop
  always_ff @(posedge ref_clk) begin
    if (!rst_n || mask_ff) begin
      intReq_ff <= 1'b0;
    end else if (intCombined) begin
      intReq_ff <= 1'b1;
    end
  end

  // RQ17 mask holds external path in reset as well
  always_ff @(posedge ref_clk) begin
    if (!rst_n || mask_ff) begin
      extReq_ff <= 1'b0;
    end else begin
      extReq_ff <= extMaskableRequest | strobeFlag;
    end
  end

  // nmi is edge triggered and cleared once its vector is taken
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      nmi_ff     <= 1'b0;
      nmiPrev_ff <= 1'b0;
    end else begin
      nmiPrev_ff <= nmiIn;
      if (nmiIn && !nmiPrev_ff) begin
        nmi_ff <= 1'b1;
      end else if (vecSel && seqKind == SEQ_IRQ && nxt_code == CODE_NMI) begin
        nmi_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // priority encoder
  // ----------------------------------------------------------------
  // RQ1 internal ranking, serial as default
  // RQ6 nothing active falls to the serial vector
  // RQ11 fixed top pairs for reset and trap
  // RQ12 external and strobe share one code
  // RQ13 capture, compare, overflow descend
  // RQ14 serial lowest pair
  always_comb begin
    nxt_code = CODE_SERIAL;
    if (seqKind == SEQ_RESET) begin
      nxt_code = CODE_RESET;
    end else if (seqKind == SEQ_TRAP) begin
      nxt_code = CODE_TRAP;
    end else if (nmi_ff) begin
      nxt_code = CODE_NMI;
    end else if (extReq_ff) begin
      nxt_code = CODE_EXT;
    end else if (capTerm) begin
      nxt_code = CODE_CAP;
    end else if (cmpTerm) begin
      nxt_code = CODE_CMP;
    end else if (ovfTerm) begin
      nxt_code = CODE_OVF;
    end
  end

  // RQ15 placement from mode table
  // RQ16 mode 0 stays external just after reset
  always_comb begin
    nxt_route = ROUTE_BY_MODE[{mode_ff, 1'b0} +: 2];
    if (mode_ff == 3'h0 && sinceReset_ff < EXT_CYCLES) begin
      nxt_route = ROUTE_EXT;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sinceReset_ff <= 2'h0;
    end else if (sinceReset_ff < EXT_CYCLES) begin
      sinceReset_ff <= sinceReset_ff + 2'h1;
    end
  end

  // RQ18 code lands on A1..A3
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      vecValid_ff <= 1'b0;
      vecAddr_ff  <= VEC_BASE;
      vecRoute_ff <= ROUTE_EXT;
      lastCode_ff <= CODE_SERIAL;
    end else begin
      vecValid_ff <= vecSel;
      if (vecSel) begin
        vecAddr_ff  <= {VEC_BASE[15:4], nxt_code, 1'b0};
        vecRoute_ff <= nxt_route;
        lastCode_ff <= nxt_code;
      end
    end
  end

  // RQ8 pending follows the flops, not the encoder inputs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pending_ff <= 1'b0;
    end else begin
      pending_ff <= nmi_ff | extReq_ff | intReq_ff;
    end
  end

  // ----------------------------------------------------------------
  // avalon-mm slave
  // ----------------------------------------------------------------
  // one wait cycle, then the access completes with waitrequest low
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      waitReq_ff <= 1'b1;
    end else begin
      waitReq_ff <= ~((avs_read | avs_write) & waitReq_ff);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      readData_ff <= 32'h0000_0000;
    end else if (avs_read && waitReq_ff) begin
      unique case (avs_address)
        COND_OFS:   readData_ff <= {27'h000_0000, mask_ff, 4'h0};
        ENABLE_OFS: readData_ff <= {27'h000_0000, enable_ff};
        STATUS_OFS: readData_ff <= {25'h000_0000, lastCode_ff, mask_ff,
                                    nmi_ff, extReq_ff, intReq_ff};
        MODE_OFS:   readData_ff <= {29'h000_0000, mode_ff};
        default:    readData_ff <= 32'h0000_0000;
      endcase
    end
  end

  // enables feed the encoder directly, a cleared enable drops out at once
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      enable_ff <= ENABLE_RST;
      mode_ff   <= MODE_RST;
    end else if (busAccess && avs_write) begin
      if (avs_address == ENABLE_OFS) begin
        enable_ff <= avs_writedata[4:0];
      end
      if (avs_address == MODE_OFS) begin
        mode_ff <= avs_writedata[2:0];
      end
    end
  end

  assign avs_readdata    = readData_ff;
  assign avs_waitrequest = waitReq_ff;
  assign irqPending      = pending_ff;
  assign vecValid        = vecValid_ff;
  assign vecAddr         = vecAddr_ff;
  assign vecRoute        = vecRoute_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  int cmpCnt;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cmpCnt <= 0;
    end else if (intReq_ff && !mask_ff) begin
      cmpCnt <= cmpCnt + 1;
    end else begin
      cmpCnt <= 0;
    end
  end

  int_sticky_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ3
    intReq_ff && !mask_ff |=> intReq_ff)
    else $error("internal request dropped while mask clear");

  int_set_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ10
    intCombined && !mask_ff |=> intReq_ff)
    else $error("internal request not set by active term");

  mask_clears_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ7
    mask_ff |=> !intReq_ff && !extReq_ff)
    else $error("maskable flop survived a set mask");

  mask_fast_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ19
    setMaskOp |=> mask_ff)
    else $error("mask set was delayed");

  mask_slow_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ19
    clearMaskOp && !setMaskOp && !maskWrite && mask_ff |=> mask_ff ##1 !mask_ff)
    else $error("mask clear not delayed one cycle");

  serial_default_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ6
    vecSel && seqKind == SEQ_IRQ && !nmi_ff && !extReq_ff && !capTerm && !cmpTerm
      && !ovfTerm |=> vecValid && vecAddr == 16'hFFF0)
    else $error("default vector not serial");

  cap_vector_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ13
    vecSel && seqKind == SEQ_IRQ && !nmi_ff && !extReq_ff && capTerm
      |=> vecAddr == 16'hFFF6)
    else $error("capture vector wrong");

  reset_vector_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ11
    vecSel && seqKind == SEQ_RESET |=> vecAddr == 16'hFFFE)
    else $error("reset vector wrong");

  mode0_route_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ16
    vecSel && mode_ff == 3'h0 && sinceReset_ff == 2'h2 |=> vecRoute == ROUTE_ROM)
    else $error("mode 0 vector not internal after reset");

  pending_hold_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ8
    cmpCnt > 1 |-> irqPending)
    else $error("pending lost while internal flop set");

  bus_answer_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");

endmodule // ipv_irq_vector_select

// file: ipv_pkg.sv
// constants for the interrupt priority and vector selection block
// assumes a 32-bit avalon-mm register bus and a 100 MHz e-cycle clock

package ipv_pkg;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] COND_OFS   = 4'h0;
  localparam logic [3:0] ENABLE_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h8;
  localparam logic [3:0] MODE_OFS   = 4'hC;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MASK_BIT    = 4;
  localparam int EN_CAP_BIT  = 0;
  localparam int EN_CMP_BIT  = 1;
  localparam int EN_OVF_BIT  = 2;
  localparam int EN_RX_BIT   = 3;
  localparam int EN_TX_BIT   = 4;
  localparam int ST_INT_BIT  = 0;
  localparam int ST_EXT_BIT  = 1;
  localparam int ST_NMI_BIT  = 2;
  localparam int ST_MASK_BIT = 3;
  localparam int ST_CODE_LSB = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] ENABLE_RST = 5'h00;
  localparam logic [2:0] MODE_RST   = 3'h0;

  // ----------------------------------------------------------------
  // vector table: address = base + 2 * priority code (A1..A3)
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_BASE = 16'hFFF0;
  localparam logic [2:0] CODE_SERIAL  = 3'h0;
  localparam logic [2:0] CODE_OVF     = 3'h1;
  localparam logic [2:0] CODE_CMP     = 3'h2;
  localparam logic [2:0] CODE_CAP     = 3'h3;
  localparam logic [2:0] CODE_EXT     = 3'h4;
  localparam logic [2:0] CODE_TRAP    = 3'h5;
  localparam logic [2:0] CODE_NMI     = 3'h6;
  localparam logic [2:0] CODE_RESET   = 3'h7;

  // ----------------------------------------------------------------
  // mode dependent vector placement
  // ----------------------------------------------------------------
  localparam logic [1:0] ROUTE_EXT = 2'h0;
  localparam logic [1:0] ROUTE_ROM = 2'h1;
  localparam logic [1:0] ROUTE_RAM = 2'h2;
  // two bits per mode, mode 0 in the low pair
  localparam logic [15:0] ROUTE_BY_MODE = 16'h0009;
  localparam logic [1:0]  EXT_CYCLES    = 2'h2;

  typedef enum logic [1:0] {
    SEQ_RESET = 2'b00,
    SEQ_TRAP  = 2'b01,
    SEQ_IRQ   = 2'b10
  } ipv_seq_t;

endpackage

// file: ipv_core_model.sv
// partner model: core sequencer pulses plus timer, serial and external request levels
// assumes callers invoke its tasks right at a rising edge of ref_clk
`timescale 1ns/10ps

module ipv_core_model (
  input  wire logic        ref_clk,
  output logic             vecSel,
  output ipv_pkg::ipv_seq_t seqKind,
  output logic             setMaskOp,
  output logic             clearMaskOp,
  output logic             nmiIn,
  output logic             extMaskableRequest,
  output logic             strobeFlag,
  output logic             captureFlag,
  output logic             compareFlag,
  output logic             overflowFlag,
  output logic             rxFullFlag,
  output logic             overrunFramingFlag,
  output logic             txEmptyFlag
);
  import ipv_pkg::*;

  initial begin
    vecSel      = 1'b0;
    seqKind     = SEQ_IRQ;
    setMaskOp   = 1'b0;
    clearMaskOp = 1'b0;
    nmiIn              = 1'b0;
    extMaskableRequest = 1'b0;
    strobeFlag         = 1'b0;
    captureFlag        = 1'b0;
    compareFlag        = 1'b0;
    overflowFlag       = 1'b0;
    rxFullFlag         = 1'b0;
    overrunFramingFlag = 1'b0;
    txEmptyFlag        = 1'b0;
  end

  // ----------------------------------------------------------------
  // sequencer side
  // ----------------------------------------------------------------
  // one-cycle vector pulse, kind held with it
  task automatic do_vec(input ipv_seq_t kind);
    vecSel  <= 1'b1;
    seqKind <= kind;
    @(posedge ref_clk);
    vecSel  <= 1'b0;
  endtask

  // mask ops are single-cycle pulses, never both at once
  task automatic mask_op(input logic setIt);
    setMaskOp   <= setIt;
    clearMaskOp <= !setIt;
    @(posedge ref_clk);
    setMaskOp   <= 1'b0;
    clearMaskOp <= 1'b0;
  endtask

  // flags change as levels at a rising edge; two calls in a row give a one-cycle level,
  // which models a flag cleared at once
  task automatic drive_src(input logic [8:0] v);
    @(posedge ref_clk);
    nmiIn              <= v[8];
    extMaskableRequest <= v[7];
    strobeFlag         <= v[6];
    captureFlag        <= v[5];
    compareFlag        <= v[4];
    overflowFlag       <= v[3];
    rxFullFlag         <= v[2];
    overrunFramingFlag <= v[1];
    txEmptyFlag        <= v[0];
  endtask
endmodule // ipv_core_model

// file: testbench.sv
// testbench: register accesses, vector cycles and request patterns against expected values
// assumes ipv_pkg, the design and ipv_core_model are compiled before it
`timescale 1ns/10ps

module testbench;
  import ipv_pkg::*;

  logic        ref_clk;
  logic        rst_n;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        vecSel;
  ipv_seq_t    seqKind;
  logic        setMaskOp;
  logic        clearMaskOp;
  logic        nmiIn;
  logic        extMaskableRequest;
  logic        strobeFlag;
  logic        captureFlag;
  logic        compareFlag;
  logic        overflowFlag;
  logic        rxFullFlag;
  logic        overrunFramingFlag;
  logic        txEmptyFlag;
  logic        irqPending;
  logic        vecValid;
  logic [15:0] vecAddr;
  logic [1:0]  vecRoute;
  logic [31:0] rdVal;
  int          miscompares = 0;
  int          n_checks = 0;
  // source order: nmi, ext, strobe, capture, compare, overflow, rx, overrun, tx
  logic [8:0]  srcTab [9] = '{9'h038, 9'h018, 9'h008, 9'h004, 9'h002, 9'h001,
                              9'h0A0, 9'h040, 9'h1A0};
  logic [15:0] vecTab [9] = '{16'hFFF6, 16'hFFF4, 16'hFFF2, 16'hFFF0, 16'hFFF0,
                              16'hFFF0, 16'hFFF8, 16'hFFF8, 16'hFFFC};

  ipv_irq_vector_select ipv_irq_vector_select_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .nmiIn(nmiIn),
    .extMaskableRequest(extMaskableRequest), .strobeFlag(strobeFlag),
    .captureFlag(captureFlag), .compareFlag(compareFlag), .overflowFlag(overflowFlag),
    .rxFullFlag(rxFullFlag), .overrunFramingFlag(overrunFramingFlag),
    .txEmptyFlag(txEmptyFlag), .setMaskOp(setMaskOp),
    .clearMaskOp(clearMaskOp), .vecSel(vecSel), .seqKind(seqKind),
    .irqPending(irqPending), .vecValid(vecValid), .vecAddr(vecAddr), .vecRoute(vecRoute));

  ipv_core_model ipv_core_model_inst (
    .ref_clk(ref_clk), .vecSel(vecSel), .seqKind(seqKind), .setMaskOp(setMaskOp),
    .clearMaskOp(clearMaskOp), .nmiIn(nmiIn), .extMaskableRequest(extMaskableRequest),
    .strobeFlag(strobeFlag), .captureFlag(captureFlag), .compareFlag(compareFlag),
    .overflowFlag(overflowFlag), .rxFullFlag(rxFullFlag),
    .overrunFramingFlag(overrunFramingFlag), .txEmptyFlag(txEmptyFlag));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // request held until waitrequest is sampled low; data taken at that edge
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
    @(posedge ref_clk);
    avs_address   <= adr;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    rdVal = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic vec_chk(input ipv_seq_t k, input logic [15:0] a, input logic [1:0] r);
    @(posedge ref_clk);
    ipv_core_model_inst.do_vec(k);
    #1;
    chk("vecValid", {31'h0, vecValid}, 32'h0000_0001);
    chk("vecAddr", {16'h0000, vecAddr}, {16'h0000, a});
    chk("vecRoute", {30'h0, vecRoute}, {30'h0, r});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    rst_n         <= 1'b0;
    avs_address   <= 4'h0;
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    avs_writedata <= 32'h0000_0000;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    ipv_core_model_inst.do_vec(SEQ_RESET);
    #1;
    chk("reset vector", {16'h0000, vecAddr}, 32'h0000_FFFE);
    chk("reset route", {30'h0, vecRoute}, {30'h0, ROUTE_EXT});
    bus(1'b0, COND_OFS, 32'h0);
    chk("cond reset", rdVal, 32'h0000_0010);
    bus(1'b0, ENABLE_OFS, 32'h0);
    chk("enable reset", rdVal, 32'h0000_0000);
    bus(1'b1, 4'h6, 32'h0000_001F);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped read", rdVal, 32'h0000_0000);
    bus(1'b0, ENABLE_OFS, 32'h0);
    chk("enable after stray write", rdVal, 32'h0000_0000);
    bus(1'b1, ENABLE_OFS, 32'h0000_001F);
    ipv_core_model_inst.drive_src(9'h020);
    settle(3);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk("masked status", {28'h0, rdVal[3:0]}, 32'h0000_0008);
    chk("masked pending", {31'h0, irqPending}, 32'h0000_0000);
    bus(1'b1, COND_OFS, 32'h0000_0000);
    settle(3);
    chk("pending", {31'h0, irqPending}, 32'h0000_0001);
    vec_chk(SEQ_IRQ, 16'hFFF6, ROUTE_ROM);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk("status code", rdVal, 32'h0000_0031);
    for (int i = 0; i < 9; i++) begin
      ipv_core_model_inst.drive_src(srcTab[i]);
      settle(3);
      vec_chk(SEQ_IRQ, vecTab[i], ROUTE_ROM);
    end
    vec_chk(SEQ_TRAP, 16'hFFFA, ROUTE_ROM);
    ipv_core_model_inst.drive_src(9'h000);
    @(posedge ref_clk);
    ipv_core_model_inst.mask_op(1'b1);
    settle(2);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk("flops cleared", {28'h0, rdVal[3:0]}, 32'h0000_0008);
    bus(1'b1, COND_OFS, 32'h0000_0000);
    settle(2);
    ipv_core_model_inst.drive_src(9'h008);
    ipv_core_model_inst.drive_src(9'h000);
    settle(3);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk("pulse latched", {28'h0, rdVal[3:0]}, 32'h0000_0001);
    vec_chk(SEQ_IRQ, 16'hFFF0, ROUTE_ROM);
    // enable cleared after flop set, flop emptied by the mask first
    @(posedge ref_clk);
    ipv_core_model_inst.mask_op(1'b1);
    bus(1'b1, COND_OFS, 32'h0000_0000);
    ipv_core_model_inst.drive_src(9'h020);
    bus(1'b1, ENABLE_OFS, 32'h0000_0000);
    settle(2);
    chk("still pending", {31'h0, irqPending}, 32'h0000_0001);
    vec_chk(SEQ_IRQ, 16'hFFF0, ROUTE_ROM);
    // mask around enable clear drops stale request
    @(posedge ref_clk);
    ipv_core_model_inst.mask_op(1'b1);
    bus(1'b1, ENABLE_OFS, 32'h0000_001E);
    bus(1'b0, COND_OFS, 32'h0);
    chk("mask set", rdVal, 32'h0000_0010);
    @(posedge ref_clk);
    ipv_core_model_inst.mask_op(1'b0);
    settle(3);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk("stale dropped", {28'h0, rdVal[3:0]}, 32'h0000_0000);
    chk("none pending", {31'h0, irqPending}, 32'h0000_0000);
    ipv_core_model_inst.drive_src(9'h000);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, MODE_OFS, 32'(m));
      bus(1'b0, MODE_OFS, 32'h0);
      chk("mode", rdVal, 32'(m));
      vec_chk(SEQ_IRQ, 16'hFFF0, ROUTE_BY_MODE[2*m +: 2]);
    end
    // a second reset in mid-run brings back external placement
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    ipv_core_model_inst.do_vec(SEQ_RESET);
    #1;
    chk("reset vector again", {16'h0000, vecAddr}, 32'h0000_FFFE);
    chk("reset route again", {30'h0, vecRoute}, {30'h0, ROUTE_EXT});
    bus(1'b0, MODE_OFS, 32'h0);
    chk("mode after reset", rdVal, {29'h0, MODE_RST});
    wrap_up();
  end

  // hang guard: the whole sequence needs well under 2000 cycles
  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end
endmodule // testbench
